// [pkg/oscr_pkg.sv]
// Constants and types for the output stream configuration registers
package oscr_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PATTERN_TWO_LOW  = 8'h1b;
    localparam logic [7:0] ADDR_PATTERN_TWO_HIGH = 8'h1c;
    localparam logic [7:0] ADDR_STREAM_FORMAT    = 8'h21;
    localparam logic [7:0] ADDR_LANE_POWER_RST   = 8'h22;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PATTERN_TWO_LOW  = 8'h00;
    localparam logic [7:0] RST_PATTERN_TWO_HIGH = 8'h00;
    localparam logic [7:0] RST_STREAM_FORMAT    = 8'h00;
    localparam logic [7:0] RST_LANE_POWER_RST   = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED       = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FMT_LSB_FIRST_BIT = 7;
    localparam int FMT_LOW_RATE_BIT  = 3;
    localparam int FMT_RES_MSB       = 2;
    localparam int FMT_RES_LSB       = 0;
    localparam int LANE_OUT_RST_BIT  = 1;
    localparam int LANE_PWR_DN_BIT   = 0;

    // Writable bit masks, all others read as zero
    localparam logic [7:0] FMT_WR_MASK  = 8'h8f;
    localparam logic [7:0] LANE_WR_MASK = 8'h03;

    // ------------------------------------------------------------------
    // Resolution codes and word widths
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OSCR_RES_NATIVE = 3'b000,
        OSCR_RES_8      = 3'b001,
        OSCR_RES_10     = 3'b010,
        OSCR_RES_12     = 3'b011,
        OSCR_RES_14     = 3'b100
    } oscr_res_e;

    localparam logic [3:0] BITS_8  = 4'h8;
    localparam logic [3:0] BITS_10 = 4'ha;
    localparam logic [3:0] BITS_12 = 4'hc;
    localparam logic [3:0] BITS_14 = 4'he;

    localparam int NUM_CHANNELS = 4;

endpackage : oscr_pkg

// [core/oscr_lane_ctl.sv]
// Per-channel output reset and power-down control bits
`timescale 1ns/100ps
module oscr_lane_ctl
    import oscr_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_bits,
    output logic            out_reset,
    output logic            power_down
);

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    logic [1:0] bits_reg;
    logic [1:0] bits_next;

    assign bits_next = wr_en ? wr_bits : bits_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bits_reg <= RST_LANE_POWER_RST[1:0];
        end else begin
            bits_reg <= bits_next;
        end
    end

    assign out_reset  = bits_reg[LANE_OUT_RST_BIT];
    assign power_down = bits_reg[LANE_PWR_DN_BIT];

endmodule : oscr_lane_ctl

// [core/oscr_regs.sv]
// Output stream configuration register bank with per-channel controls
`timescale 1ns/100ps

// Overview of operation
// - Byte register for pattern two bits 7..0, resets to zero, host writable.
// - Byte register for pattern two bits 15..8, resets to zero, host writable.
// - Format register picks word width code and LSB-first order in top bit.
// - Lane register bit 1 holds selected channel output in reset when set.
// - Lane register bit 0 powers down selected channel locally when set.
module oscr_regs
    import oscr_pkg::*;
#(
    parameter int NUM_CH = NUM_CHANNELS
)
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic [NUM_CH-1:0] chan_select,
    output logic      [7:0]        reg_rdata,
    output logic                   reg_rd_valid,
    output logic      [15:0]       pattern_two,
    output logic                   lsb_first,
    output logic                   low_rate_mode,
    output logic      [2:0]        resolution_code,
    output logic      [3:0]        word_bits,
    output logic      [NUM_CH-1:0] chan_out_reset,
    output logic      [NUM_CH-1:0] chan_power_down
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [2:0] effective_res(input logic [2:0] code);
        logic [2:0] res;
        res = code;
        if (code > OSCR_RES_14) begin
            res = OSCR_RES_NATIVE;
        end
        return res;
    endfunction : effective_res

    function automatic logic [3:0] res_to_bits(input logic [2:0] code);
        logic [3:0] nbits;
        nbits = BITS_10;
        case (code)
            OSCR_RES_8: begin
                nbits = BITS_8;
            end
            OSCR_RES_12: begin
                nbits = BITS_12;
            end
            OSCR_RES_14: begin
                nbits = BITS_14;
            end
            default: begin
                nbits = BITS_10;
            end
        endcase
        return nbits;
    endfunction : res_to_bits

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire hit_low  = (reg_addr == ADDR_PATTERN_TWO_LOW);
    wire hit_high = (reg_addr == ADDR_PATTERN_TWO_HIGH);
    wire hit_fmt  = (reg_addr == ADDR_STREAM_FORMAT);
    wire hit_lane = (reg_addr == ADDR_LANE_POWER_RST);

    wire wr_low  = reg_wr_en && hit_low;
    wire wr_high = reg_wr_en && hit_high;
    wire wr_fmt  = reg_wr_en && hit_fmt;
    wire wr_lane = reg_wr_en && hit_lane;

    // ------------------------------------------------------------------
    // Global registers
    // ------------------------------------------------------------------
    logic [7:0] pat_low_reg;
    logic [7:0] pat_low_next;
    logic [7:0] pat_high_reg;
    logic [7:0] pat_high_next;
    logic [7:0] fmt_reg;
    logic [7:0] fmt_next;

    assign pat_low_next  = wr_low ? reg_wdata : pat_low_reg;
    assign pat_high_next = wr_high ? reg_wdata : pat_high_reg;
    assign fmt_next      = wr_fmt ? (reg_wdata & FMT_WR_MASK)
                                  : fmt_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pat_low_reg  <= RST_PATTERN_TWO_LOW;
            pat_high_reg <= RST_PATTERN_TWO_HIGH;
            fmt_reg      <= RST_STREAM_FORMAT;
        end else begin
            pat_low_reg  <= pat_low_next;
            pat_high_reg <= pat_high_next;
            fmt_reg      <= fmt_next;
        end
    end

    // ------------------------------------------------------------------
    // Stream format decode
    // ------------------------------------------------------------------
    // Decoded from the next format value so both follow a write together
    wire [2:0] res_field = fmt_next[FMT_RES_MSB:FMT_RES_LSB];

    logic [2:0] res_reg;
    logic [2:0] res_next;
    logic [3:0] bits_reg;
    logic [3:0] bits_next;

    assign res_next  = effective_res(res_field);
    assign bits_next = res_to_bits(res_next);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            res_reg  <= OSCR_RES_NATIVE;
            bits_reg <= BITS_10;
        end else begin
            res_reg  <= res_next;
            bits_reg <= bits_next;
        end
    end

    assign pattern_two     = {pat_high_reg, pat_low_reg};
    assign lsb_first       = fmt_reg[FMT_LSB_FIRST_BIT];
    assign low_rate_mode   = fmt_reg[FMT_LOW_RATE_BIT];
    assign resolution_code = res_reg;
    assign word_bits       = bits_reg;

    // ------------------------------------------------------------------
    // Per-channel controls
    // ------------------------------------------------------------------
    wire [1:0] lane_wbits = reg_wdata[1:0] & LANE_WR_MASK[1:0];

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_lane
            oscr_lane_ctl u_lane (
                .mclk       (mclk),
                .rst_n      (rst_n),
                .wr_en      (wr_lane && chan_select[ch]),
                .wr_bits    (lane_wbits),
                .out_reset  (chan_out_reset[ch]),
                .power_down (chan_power_down[ch])
            );
        end
    endgenerate

    // Lowest selected channel answers a read of the lane register
    logic [7:0] lane_rd;

    always_comb begin
        lane_rd = 8'h00;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (chan_select[i]) begin
                lane_rd = {6'h00, chan_out_reset[i], chan_power_down[i]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire [7:0] rd_mux = hit_low  ? pat_low_reg  :
                        hit_high ? pat_high_reg :
                        hit_fmt  ? fmt_reg      :
                        hit_lane ? lane_rd      : RDATA_UNMAPPED;

    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       rvalid_reg;

    assign rdata_next = reg_rd_en ? rd_mux : rdata_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= reg_rd_en;
        end
    end

    assign reg_rdata    = rdata_reg;
    assign reg_rd_valid = rvalid_reg;

endmodule : oscr_regs

// [bench/oscr_props.sv]
// Checker for the stream configuration registers
`timescale 1ns/100ps
module oscr_props
    import oscr_pkg::*;
#(parameter int NUM_CH = NUM_CHANNELS)
(
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              reg_wr_en,
    input wire logic              reg_rd_en,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_rd_valid,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [NUM_CH-1:0] chan_select,
    input wire logic [15:0]       pattern_two,
    input wire logic              lsb_first,
    input wire logic [2:0]        resolution_code,
    input wire logic [3:0]        word_bits,
    input wire logic [NUM_CH-1:0] chan_out_reset,
    input wire logic [NUM_CH-1:0] chan_power_down
);
    // ------
    // Checks
    // ------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic              w = reg_wr_en;
    wire logic [7:0]        a = reg_addr;
    wire logic [7:0]        d = reg_wdata;
    wire logic [2:0]        c = reg_wdata[2:0];
    wire logic [2:0]        r = resolution_code;
    wire logic [NUM_CH-1:0] s = chan_select;
    wire logic [NUM_CH-1:0] m = {NUM_CH{d[1]}} & s | chan_out_reset & ~s;
    wire logic [NUM_CH-1:0] p = {NUM_CH{d[0]}} & s | chan_power_down & ~s;
    low_byte_a: assert property (
        w && a == 8'h1b |=> pattern_two[7:0] == $past(d)) else $error("low");
    high_byte_a: assert property (
        w && a == 8'h1c |=> pattern_two[15:8] == $past(d)) else $error("high");
    bit_order_a: assert property (
        w && a == 8'h21 |=> lsb_first == $past(d[7])) else $error("order");
    width_code_a: assert property (
        w && a == 8'h21 && c < 3'h5 |=> r == $past(c)) else $error("code");
    reserved_code_a: assert property (
        w && a == 8'h21 && c > 3'h4 |=> r == 3'h0) else $error("reserved");
    width_map_a: assert property (
        word_bits == (|r ? 4'h6 + {r, 1'b0} : 4'ha)) else $error("width");
    out_reset_a: assert property (
        w && a == 8'h22 |=> chan_out_reset == $past(m)) else $error("reset");
    power_down_a: assert property (
        w && a == 8'h22 |=> chan_power_down == $past(p)) else $error("power");
    low_read_a: assert property (
        reg_rd_en && a == 8'h1b |=> reg_rdata == $past(pattern_two[7:0]))
        else $error("low read");
    high_read_a: assert property (
        reg_rd_en && a == 8'h1c |=> reg_rdata == $past(pattern_two[15:8]))
        else $error("high read");
    read_valid_a: assert property (
        reg_rd_valid == $past(reg_rd_en)) else $error("read valid");
endmodule : oscr_props
bind oscr_regs oscr_props #(.NUM_CH(NUM_CH)) u_props (.*);

// [bench/oscr_host.sv]
// Parallel register bus host model issuing register writes and reads
`timescale 1ns/100ps
module oscr_host (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    // ------
    // Cycles
    // ------
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h5a;
        reg_wdata = 8'ha5;
    end
    // Released lines show the inverse of their last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge mclk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        @(posedge mclk);
        q = reg_rd_valid ? reg_rdata : ~reg_rdata;
    endtask : rd
endmodule : oscr_host

// [bench/tb.sv]
// Self-checking bench for the stream configuration registers
`timescale 1ns/100ps
module tb;
    import oscr_pkg::*;
    logic        mclk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid;
    logic        lsb_first, low_rate_mode;
    logic [3:0]  chan_select, word_bits, chan_out_reset, chan_power_down;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, got, lo, hi, fmt;
    logic [15:0] pattern_two, lfsr;
    logic [2:0]  resolution_code;
    logic [3:0]  ore, opd;
    logic [7:0]  adr [5] = '{8'h1b, 8'h1c, 8'h21, 8'h22, 8'h20};
    int          n_fail, compares, k;
    oscr_host h (.mclk, .reg_rdata, .reg_rd_valid, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wdata);
    oscr_regs #(.NUM_CH(4)) dut (.mclk, .rst_n, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wdata, .chan_select, .reg_rdata, .reg_rd_valid,
        .pattern_two, .lsb_first, .low_rate_mode, .resolution_code,
        .word_bits, .chan_out_reset, .chan_power_down);
    // ------
    // Checks
    // ------
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    function automatic logic [2:0] eff(input logic [2:0] c);
        return c > 3'h4 ? 3'h0 : c;
    endfunction : eff
    task automatic chk(input string n, input logic [15:0] e, g);
        compares++;
        if (e !== g) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic outs();
        logic [2:0] r;
        @(negedge mclk);
        r = eff(fmt[2:0]);
        chk("pattern_two", {hi, lo}, pattern_two);
        chk("lsb_first", fmt[7], lsb_first);
        chk("low_rate_mode", fmt[3], low_rate_mode);
        chk("resolution_code", r, resolution_code);
        chk("word_bits", |r ? 4'h6 + {r, 1'b0} : 4'ha, word_bits);
        chk("chan_out_reset", ore, chan_out_reset);
        chk("chan_power_down", opd, chan_power_down);
    endtask : outs
    task automatic rchk(input logic [7:0] a);
        logic [7:0] e;
        h.rd(a, got);
        k = 0;
        while (k < 4 && !chan_select[k]) k++;
        e = a == 8'h22 && k < 4 ? {6'h00, ore[k], opd[k]} : 8'h00;
        if (a == 8'h1b) e = lo;
        if (a == 8'h1c) e = hi;
        if (a == 8'h21) e = fmt;
        chk("reg_rdata", e, got);
    endtask : rchk
    task automatic step(input logic [7:0] a, input logic [7:0] d);
        h.wr(a, d);
        if (a == ADDR_PATTERN_TWO_LOW) lo = d;
        if (a == ADDR_PATTERN_TWO_HIGH) hi = d;
        if (a == ADDR_STREAM_FORMAT) fmt = d & FMT_WR_MASK;
        if (a == ADDR_LANE_POWER_RST) begin
            ore = ore & ~chan_select | {4{d[1]}} & chan_select;
            opd = opd & ~chan_select | {4{d[0]}} & chan_select;
        end
        outs();
        rchk(a);
    endtask : step
    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        {lo, hi, fmt, ore, opd} = '0;
        chan_select = 4'h1;
        lfsr = 16'hcfdf;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        outs();
        foreach (adr[i]) rchk(adr[i]);
        for (int c = 0; c < 8; c++) step(8'h21, {c[0], 3'h7, c[3:0]});
        @(posedge mclk);
        chan_select <= 4'h0;
        step(8'h22, 8'hff);
        repeat (60) begin
            lfsr = nxt(lfsr);
            @(posedge mclk);
            chan_select <= lfsr[3:0];
            step(adr[lfsr[6:4] % 5], lfsr[15:8]);
        end
        complete_run();
    end
endmodule : tb
